// ===== rtl/lhp_regs.sv
// lhp_regs: hook, filter, ground-start and pcm highway configuration block
// registers on a decoded byte port in the mclk domain; pcm pins are asynchronous
//
// How it works
// - off-hook counter length from bits 6:5: 512, 128, 64 or 8 ms; 128 default
// - on-hook speed bit: under 0.5 ms or 3 ms from request clear to zero current
// - receive corner select: 5 Hz when zero, 200 Hz when one
// - line voltage status forced to zero at 3 V or less unless disabled
// - tip ground detect reads zero while tip current flows, one otherwise
// - tip detect enable zero closes tip relay; one opens it, no detection
// - ring ground bit zero closes ring-to-ground relay; one opens it
// - analog loopback bit routes line receive data back out through transmit
// - highway transfers only while enable bit set; counts programmed beforehand
// - format field: a-law, mu-law, upper linear byte or full 16-bit linear
// - clocks-per-bit select: one or two bit clocks per data bit
// - output released after bit 0 on rising or falling bit-clock edge
// - transmit begins after ten-bit transmit start count of clocks from sync
// - receive begins after receive start count of clocks from frame sync
// - receive start count high two bits in following register bits 1:0
`timescale 1ns/1ns
`default_nettype none
`include "lhp_cfg.svh"

module lhp_regs
    import lhp_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        arst_n,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    output logic             reg_rvalid,
    // hook and line side
    input  wire logic        offhook_request,
    input  wire logic [7:0]  line_volt_raw,
    input  wire logic        tip_ground_current,
    output logic             loop_hold,
    output logic             offhook_valid,
    output logic      [7:0]  line_voltage_status,
    output logic             rx_corner_sel,
    output logic             analog_loopback_en,
    output logic             tip_relay_open,
    output logic             ring_relay_open,
    // transmit samples from codec
    input  wire logic        tx_in_valid,
    output logic             tx_in_ready,
    input  wire logic [15:0] tx_in_data,
    // received code words to codec
    output logic      [15:0] rx_word,
    output logic             rx_valid,
    // pcm highway pins
    input  wire logic        pclk,
    input  wire logic        frame_sync,
    input  wire logic        pcm_din,
    output logic             pcm_dout,
    output logic             pcm_dout_oe
);
    typedef struct packed {
        lhp_byte_t   hook;
        logic [1:0]  gsc;
        lhp_byte_t   pcm;
        lhp_byte_t   txs_lo;
        logic [1:0]  txs_hi;
        lhp_byte_t   rxs_lo;
        logic [1:0]  rxs_hi;
        lhp_byte_t   rdata;
        logic        rvalid;
        logic [1:0]  pclk_s;
        logic [1:0]  frame_sync_s;
        logic [1:0]  din_s;
        logic [1:0]  tipg_s;
        logic        pclk_d;
        logic [11:0] tick_cnt;
        logic        tick;
        logic        req_d;
        logic [12:0] hook_cnt;
        logic        loop_hold;
        logic        offhook_valid;
        logic        releasing;
        lhp_byte_t   lv;
        logic        tip_ground_detect;
        logic [9:0]  bclk_cnt;
        lhp_dir_e    tx_st;
        logic [15:0] tx_sh;
        logic [4:0]  tx_left;
        logic        tx_half;
        logic        dout;
        logic        dout_oe;
        lhp_dir_e    rx_st;
        logic [15:0] rx_sh;
        logic [4:0]  rx_left;
        logic        rx_half;
        logic [15:0] rx_word;
        logic        rx_valid;
    } lhp_state_s;

    localparam logic [11:0] TICK_LAST = 12'(`LHP_TICK_CYC - 1);
    localparam logic [12:0] SLOW_TICKS = 13'(`LHP_ONHOOK_SLOW_US / `LHP_TICK_US);
    localparam logic [12:0] FAST_TICKS = 13'(`LHP_ONHOOK_FAST_US / `LHP_TICK_US);

    lhp_state_s  st;
    lhp_state_s  next_st;
    logic        rise;
    logic        fall;
    logic        pcm_en;
    logic        clocks_per_bit_sel;
    logic [1:0]  fmt;
    logic [4:0]  nbits;
    logic [9:0]  cnt_now;
    logic        start_tx;
    logic        start_rx;
    logic [12:0] hook_target;
    logic        fifo_valid;
    logic [15:0] fifo_data;
    logic [7:0]  lv_mag;

    // companding of one 16-bit linear sample into the selected code
    function automatic logic [15:0] lhp_encode(input logic [15:0] s, input logic [1:0] f);
        logic [15:0] mag;
        logic [12:0] m13;
        logic [2:0]  seg;
        logic [3:0]  mant;
        logic        pos;
        mag  = s[15] ? 16'(~s + 16'h0001) : s;
        pos  = !s[15];
        seg  = 3'h0;
        m13  = 13'h0000;
        mant = 4'h0;
        if (f == 2'b01) begin
            m13 = (mag[15:2] > 14'h1FDE) ? 13'h1FFF : 13'(mag[15:2] + 14'h0021);
            for (int i = 5; i <= 12; i++) begin
                if (m13[i]) begin
                    seg = 3'(i - 5);
                end
            end
            mant = 4'(m13 >> (seg + 3'h1));
            lhp_encode = {~{pos, seg, mant}, 8'h00};
        end else if (f == 2'b00) begin
            m13 = mag[15:3];
            for (int i = 5; i <= 11; i++) begin
                if (m13[i]) begin
                    seg = 3'(i - 4);
                end
            end
            mant = (seg == 3'h0) ? 4'(m13 >> 1) : 4'(m13 >> seg);
            lhp_encode = {{pos, seg, mant} ^ 8'h55, 8'h00};
        end else begin
            lhp_encode = s;
        end
    endfunction

    assign pcm_en   = st.pcm[`LHP_HIGHWAY_TRANSFER_EN_BIT];
    assign clocks_per_bit_sel     = st.pcm[`LHP_CLOCKS_PER_BIT_SEL_BIT];
    assign fmt      = st.pcm[`LHP_FMT_HI:`LHP_FMT_LO];
    assign nbits    = (fmt == 2'b11) ? 5'h10 : 5'h08;
    assign rise     = st.pclk_s[1] && !st.pclk_d;
    assign fall     = !st.pclk_s[1] && st.pclk_d;
    // the clock that sees frame sync is count zero
    assign cnt_now  = st.frame_sync_s[1] ? 10'h000 : 10'(st.bclk_cnt + 10'h001);
    assign start_tx = rise && pcm_en && (cnt_now == {st.txs_hi, st.txs_lo});
    assign start_rx = rise && pcm_en && (cnt_now == {st.rxs_hi, st.rxs_lo});
    assign lv_mag   = line_volt_raw[7] ? 8'(~line_volt_raw + 8'h01) : line_volt_raw;

    always_comb begin
        case (st.hook[`LHP_FOH_HI:`LHP_FOH_LO])
            2'b00:   hook_target = 13'(`LHP_OFFHOOK_MS_00 * 1000 / `LHP_TICK_US);
            2'b01:   hook_target = 13'(`LHP_OFFHOOK_MS_01 * 1000 / `LHP_TICK_US);
            2'b10:   hook_target = 13'(`LHP_OFFHOOK_MS_10 * 1000 / `LHP_TICK_US);
            default: hook_target = 13'(`LHP_OFFHOOK_MS_11 * 1000 / `LHP_TICK_US);
        endcase
        if (st.releasing) begin
            hook_target = st.hook[`LHP_OHS_BIT] ? SLOW_TICKS : FAST_TICKS;
        end
    end

    // the fifo absorbs codec samples while the highway is off or between frames
    lhp_fifo #(
        .WIDTH (16),
        .DEPTH (16),
        .AW    (4)
    ) i_lhp_fifo (
        .mclk      (mclk),
        .arst_n    (arst_n),
        .in_valid  (tx_in_valid),
        .in_ready  (tx_in_ready),
        .in_data   (tx_in_data),
        .out_valid (fifo_valid),
        .out_ready (start_tx),
        .out_data  (fifo_data)
    );

    always_comb begin
        next_st = st;
        // register port; reserved bits are masked and read back as zero
        next_st.rvalid = reg_rd;
        if (reg_wr) begin
            case (reg_addr)
                `LHP_ADDR_HOOK:   next_st.hook   = reg_wdata & `LHP_HOOK_MASK;
                `LHP_ADDR_GSC:    next_st.gsc    = reg_wdata[1:0];
                `LHP_ADDR_PCM:    next_st.pcm    = reg_wdata & `LHP_PCM_MASK;
                `LHP_ADDR_TXS_LO: next_st.txs_lo = reg_wdata;
                `LHP_ADDR_TXS_HI: next_st.txs_hi = reg_wdata[1:0];
                `LHP_ADDR_RXS_LO: next_st.rxs_lo = reg_wdata;
                `LHP_ADDR_RXS_HI: next_st.rxs_hi = reg_wdata[1:0];
                default:          next_st.hook   = st.hook;
            endcase
        end
        if (reg_rd) begin
            case (reg_addr)
                `LHP_ADDR_HOOK:   next_st.rdata = st.hook;
                `LHP_ADDR_GSC:    next_st.rdata = {5'h00, st.tip_ground_detect, st.gsc};
                `LHP_ADDR_PCM:    next_st.rdata = st.pcm;
                `LHP_ADDR_TXS_LO: next_st.rdata = st.txs_lo;
                `LHP_ADDR_TXS_HI: next_st.rdata = {6'h00, st.txs_hi};
                `LHP_ADDR_RXS_LO: next_st.rdata = st.rxs_lo;
                `LHP_ADDR_RXS_HI: next_st.rdata = {6'h00, st.rxs_hi};
                default:          next_st.rdata = 8'h00;
            endcase
        end
        // pin synchronisers
        next_st.pclk_s  = {st.pclk_s[0], pclk};
        next_st.frame_sync_s = {st.frame_sync_s[0], frame_sync};
        next_st.din_s   = {st.din_s[0], pcm_din};
        next_st.tipg_s  = {st.tipg_s[0], tip_ground_current};
        next_st.pclk_d  = st.pclk_s[1];
        // 100 us tick
        next_st.tick     = (st.tick_cnt == TICK_LAST);
        next_st.tick_cnt = next_st.tick ? 12'h000 : 12'(st.tick_cnt + 12'h001);
        // off-hook qualification and on-hook release timing
        next_st.req_d = offhook_request;
        if (offhook_request && !st.req_d) begin
            next_st.loop_hold     = 1'b1;
            next_st.releasing     = 1'b0;
            next_st.offhook_valid = 1'b0;
            next_st.hook_cnt      = 13'h0000;
        end else if (!offhook_request && st.req_d) begin
            next_st.releasing     = 1'b1;
            next_st.offhook_valid = 1'b0;
            next_st.hook_cnt      = 13'h0000;
        end else if (st.tick && st.loop_hold && !(st.offhook_valid && !st.releasing)) begin
            next_st.hook_cnt = 13'(st.hook_cnt + 13'h0001);
            if (st.hook_cnt == 13'(hook_target - 13'h0001)) begin
                next_st.offhook_valid = !st.releasing;
                next_st.loop_hold     = !st.releasing;
                next_st.releasing     = 1'b0;
            end
        end
        // zero forcing near an open line
        next_st.lv = (!st.hook[`LHP_LINE_VOLT_FORCE_DISABLE_BIT] && lv_mag <= 8'(`LHP_LV_FORCE_V)) ? 8'h00
                   : line_volt_raw;
        // with the tip relay open no current can flow, so the detect reads one
        next_st.tip_ground_detect = !(st.tipg_s[1] && !st.gsc[1]);
        // bit clock counter since frame sync
        if (rise) begin
            next_st.bclk_cnt = (cnt_now == 10'h3FF) ? st.bclk_cnt : cnt_now;
        end
        // transmit shifter
        case (st.tx_st)
            LHP_IDLE: begin
                next_st.dout_oe = 1'b0;
            end
            LHP_SHIFT: begin
                if (rise) begin
                    if (clocks_per_bit_sel && !st.tx_half) begin
                        next_st.tx_half = 1'b1;
                    end else if (st.tx_left == 5'h00) begin
                        next_st.dout_oe = 1'b0;
                        next_st.tx_st   = LHP_IDLE;
                    end else begin
                        next_st.tx_sh   = {st.tx_sh[14:0], 1'b0};
                        next_st.dout    = st.tx_sh[14];
                        next_st.tx_left = 5'(st.tx_left - 5'h01);
                        next_st.tx_half = 1'b0;
                    end
                end else if (fall && st.pcm[`LHP_TRI_BIT] && st.tx_left == 5'h00
                             && (!clocks_per_bit_sel || st.tx_half)) begin
                    next_st.dout_oe = 1'b0;
                    next_st.tx_st   = LHP_IDLE;
                end
            end
            default: begin
                next_st.tx_st = LHP_IDLE;
            end
        endcase
        if (start_tx) begin
            next_st.tx_sh   = lhp_encode(fifo_valid ? fifo_data : 16'h0000, fmt);
            next_st.dout    = next_st.tx_sh[15];
            next_st.dout_oe = 1'b1;
            next_st.tx_left = 5'(nbits - 5'h01);
            next_st.tx_half = 1'b0;
            next_st.tx_st   = LHP_SHIFT;
        end
        // receive shifter, sampled on the falling edge that ends each bit
        next_st.rx_valid = 1'b0;
        case (st.rx_st)
            LHP_IDLE: begin
                next_st.rx_half = 1'b0;
            end
            LHP_SHIFT: begin
                if (rise) begin
                    next_st.rx_half = clocks_per_bit_sel && !st.rx_half;
                end else if (fall && (!clocks_per_bit_sel || st.rx_half)) begin
                    next_st.rx_sh   = {st.rx_sh[14:0], st.din_s[1]};
                    next_st.rx_left = 5'(st.rx_left - 5'h01);
                    if (st.rx_left == 5'h01) begin
                        next_st.rx_word  = (nbits == 5'h08) ? {8'h00, st.rx_sh[6:0], st.din_s[1]}
                                         : {st.rx_sh[14:0], st.din_s[1]};
                        next_st.rx_valid = 1'b1;
                        next_st.rx_st    = LHP_IDLE;
                    end
                end
            end
            default: begin
                next_st.rx_st = LHP_IDLE;
            end
        endcase
        if (start_rx) begin
            next_st.rx_left = nbits;
            next_st.rx_half = 1'b0;
            next_st.rx_st   = LHP_SHIFT;
        end
        // clearing the enable stops the highway at once
        if (!pcm_en) begin
            next_st.tx_st   = LHP_IDLE;
            next_st.dout_oe = 1'b0;
            next_st.rx_st   = LHP_IDLE;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st        <= '0;
            st.hook   <= `LHP_HOOK_RST;
            st.gsc    <= `LHP_GSC_RST;
            st.pcm    <= `LHP_PCM_RST;
            st.tip_ground_detect    <= 1'b1;
            st.tx_st  <= LHP_IDLE;
            st.rx_st  <= LHP_IDLE;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata           = st.rdata;
    assign reg_rvalid          = st.rvalid;
    assign loop_hold           = st.loop_hold;
    assign offhook_valid       = st.offhook_valid;
    assign line_voltage_status = st.lv;
    assign rx_corner_sel       = st.hook[`LHP_RX_CORNER_SEL_BIT];
    assign analog_loopback_en  = st.pcm[`LHP_LOOP_BIT];
    assign tip_relay_open      = st.gsc[1];
    assign ring_relay_open     = st.gsc[0];
    assign rx_word             = st.rx_word;
    assign rx_valid            = st.rx_valid;
    assign pcm_dout            = st.dout;
    assign pcm_dout_oe         = st.dout_oe;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    chk_offhook_len: assert property ($rose(st.offhook_valid) |->
        $past(st.hook_cnt) == 13'(hook_target - 13'h0001))
        else $error("off-hook counter expired at wrong length");
    chk_onhook_rel: assert property ($fell(st.loop_hold) |->
        $past(st.releasing) && $past(st.hook_cnt) ==
        13'((st.hook[`LHP_OHS_BIT] ? SLOW_TICKS : FAST_TICKS) - 13'h0001))
        else $error("on-hook release time wrong");
    chk_lv_force: assert property ((!st.hook[`LHP_LINE_VOLT_FORCE_DISABLE_BIT] && lv_mag <= 8'h03) |=>
        st.lv == 8'h00)
        else $error("line voltage not forced to zero");
    chk_tip_detect: assert property ((st.tipg_s[1] && !st.gsc[1]) [*2] |->
        !st.tip_ground_detect)
        else $error("tip ground detect missed current");
    chk_pcm_off: assert property (!pcm_en |=> !st.dout_oe && st.rx_st == LHP_IDLE)
        else $error("highway active while disabled");
    chk_tri_edge: assert property ($fell(st.dout_oe) && pcm_en |->
        (st.pcm[`LHP_TRI_BIT] ? $past(fall) : $past(rise)))
        else $error("output released on wrong edge");
    chk_tx_start: assert property ($rose(st.dout_oe) |->
        $past(cnt_now) == {$past(st.txs_hi), $past(st.txs_lo)})
        else $error("transmit started at wrong count");
    chk_rx_start: assert property (start_rx |=> st.rx_st == LHP_SHIFT
        && st.rx_left == nbits)
        else $error("receive did not start on count");
    chk_rx_width: assert property (st.rx_valid && fmt != 2'b11 |->
        st.rx_word[15:8] == 8'h00)
        else $error("eight-bit word carries upper byte");

    cov_tx_word: cover property ($fell(st.dout_oe) && st.tx_left == 5'h00);
    cov_rx_word: cover property (st.rx_valid && clocks_per_bit_sel);
    cov_offhook: cover property ($rose(st.offhook_valid));
    cov_fifo_full: cover property (!tx_in_ready);

endmodule // lhp_regs

`default_nettype wire

// ===== common/lhp_cfg.svh
// lhp_cfg.svh: register offsets, field positions, reset values and timing counts
// assumes a 25 MHz core clock; included by bare name from common/
`ifndef LHP_CFG_SVH
`define LHP_CFG_SVH

// register offsets
`define LHP_ADDR_HOOK      8'h1F
`define LHP_ADDR_GSC       8'h20
`define LHP_ADDR_PCM       8'h21
`define LHP_ADDR_TXS_LO    8'h22
`define LHP_ADDR_TXS_HI    8'h23
`define LHP_ADDR_RXS_LO    8'h24
`define LHP_ADDR_RXS_HI    8'h25

// reset values and writable masks
`define LHP_HOOK_RST       8'h20
`define LHP_HOOK_MASK      8'h6B
`define LHP_GSC_RST        2'h3
`define LHP_PCM_RST        8'h00
`define LHP_PCM_MASK       8'hFB
`define LHP_HI_MASK        8'h03

// field positions
`define LHP_FOH_HI         6
`define LHP_FOH_LO         5
`define LHP_OHS_BIT        3
`define LHP_RX_CORNER_SEL_BIT       1
`define LHP_LINE_VOLT_FORCE_DISABLE_BIT       0
`define LHP_LOOP_BIT       7
`define LHP_HIGHWAY_TRANSFER_EN_BIT       5
`define LHP_FMT_HI         4
`define LHP_FMT_LO         3
`define LHP_CLOCKS_PER_BIT_SEL_BIT       1
`define LHP_TRI_BIT        0

// timing: one tick every 100 us
`define LHP_CLK_HZ         25000000
`define LHP_TICK_US        100
`define LHP_TICK_CYC       (`LHP_CLK_HZ / 1000000 * `LHP_TICK_US)
`define LHP_OFFHOOK_MS_00  512
`define LHP_OFFHOOK_MS_01  128
`define LHP_OFFHOOK_MS_10  64
`define LHP_OFFHOOK_MS_11  8
`define LHP_ONHOOK_SLOW_US 3000
`define LHP_ONHOOK_FAST_US 200
`define LHP_LV_FORCE_V     3

`endif

// ===== common/lhp_pkg.sv
// lhp_pkg: state types shared by the line hook / pcm register block
// no constants here; numbers live in lhp_cfg.svh
package lhp_pkg;

    typedef enum logic [1:0] {
        LHP_IDLE  = 2'b01,
        LHP_SHIFT = 2'b10
    } lhp_dir_e;

    typedef logic [7:0] lhp_byte_t;

endpackage

// ===== rtl/lhp_fifo.sv
// lhp_fifo: synchronous fifo with registered full and empty flags
// single clock; in_ready and out_valid come straight from flip-flops
`timescale 1ns/1ns
`default_nettype none

module lhp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             arst_n,
    // fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    typedef struct packed {
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [AW:0]   count;
        logic          full;
        logic          empty;
        logic          ready;
    } lhp_fifo_s;

    lhp_fifo_s               st;
    lhp_fifo_s               next_st;
    logic [WIDTH-1:0]        mem [DEPTH];
    logic                    push;
    logic                    pop;

    assign push      = in_valid && !st.full;
    assign pop       = out_ready && !st.empty;
    assign in_ready  = st.ready;
    assign out_valid = !st.empty;
    assign out_data  = mem[st.rptr];

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.wptr = st.wptr + 1'b1;
        end
        if (pop) begin
            next_st.rptr = st.rptr + 1'b1;
        end
        next_st.count = st.count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        next_st.full  = (next_st.count == (AW+1)'(DEPTH));
        next_st.empty = (next_st.count == '0);
        next_st.ready = !next_st.full;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            st <= '{wptr: '0, rptr: '0, count: '0, full: 1'b0, empty: 1'b1, ready: 1'b1};
        end else begin
            st <= next_st;
        end
    end

    // storage has no reset; contents are qualified by the pointers
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[st.wptr] <= in_data;
        end
    end

endmodule // lhp_fifo

`default_nettype wire

// ===== bench/lhp_hwy_master.sv
// lhp_hwy_master: pcm highway master, free bit clock, 32-clock frames
// assumes the device samples din on falling edges and drives dout after rises
`timescale 1ns/1ns
`default_nettype none

module lhp_hwy_master #(
    parameter int RX_START_COUNT = 2
) (
    output logic       pclk,
    output logic       frame_sync,
    output logic       pcm_din,
    input  wire logic  pcm_dout,
    input  wire logic  pcm_dout_oe,
    output logic [7:0] tx_cap
);
    localparam logic [7:0] RX_PAT = 8'hC3;
    int cnt = 0;
    int nb = 0;
    initial begin
        pclk = 1'b0;
        frame_sync = 1'b0;
        pcm_din = 1'b0;
        tx_cap = 8'h00;
        #7;
        forever #160 pclk = ~pclk;
    end
    // outside the word the line toggles so a stale bit is never mistaken for data
    always @(posedge pclk) begin
        cnt = (cnt + 1) % 32;
        if (cnt >= RX_START_COUNT && cnt < RX_START_COUNT + 8)
            pcm_din <= RX_PAT[7 - (cnt - RX_START_COUNT)];
        else
            pcm_din <= ~pcm_din;
    end
    // only the first eight driven bits of a frame are kept
    always @(negedge pclk) begin
        frame_sync <= (cnt == 31);
        if (frame_sync) begin
            nb <= 0;
        end else if (pcm_dout_oe && nb < 8) begin
            tx_cap <= {tx_cap[6:0], pcm_dout};
            nb <= nb + 1;
        end
    end
endmodule // lhp_hwy_master

`default_nettype wire

// ===== bench/lhp_regs_test.sv
// lhp_regs_test: register, line, hook, fifo and highway checks of lhp_regs
// assumes lhp_hwy_master drives the highway pins
`timescale 1ns/1ns
`default_nettype none

module lhp_regs_test;
    logic        mclk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, reg_rvalid;
    logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, line_volt_raw = 8'h00;
    logic [7:0]  line_voltage_status, tx_cap;
    logic        offhook_request = 0, tip_ground_current = 0, tx_in_valid = 0, tx_in_ready;
    logic        loop_hold, offhook_valid, rx_corner_sel, analog_loopback_en, rx_valid;
    logic        tip_relay_open, ring_relay_open, pclk, frame_sync, pcm_din, pcm_dout, pcm_dout_oe;
    logic [15:0] tx_in_data = 16'h0000, rx_word, rx_got = 16'h0000;
    int          n_mismatch = 0, checks_done = 0, n;
    logic [15:0] rst_rows [8] = '{16'h1F20, 16'h2007, 16'h2100, 16'h2200, 16'h2300, 16'h2400,
                                  16'h2500, 16'h3000};
    logic [23:0] wr_rows [9] = '{24'h1F_6B6B, 24'h21_DBDB, 24'h22_0101, 24'h23_FC00, 24'h24_0202,
                                 24'h25_FC00, 24'h30_FF00, 24'h20_FC04, 24'h20_FF07};

    lhp_regs i_lhp_regs (.mclk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .reg_rvalid, .offhook_request, .line_volt_raw, .tip_ground_current, .loop_hold,
        .offhook_valid, .line_voltage_status, .rx_corner_sel, .analog_loopback_en,
        .tip_relay_open, .ring_relay_open, .tx_in_valid, .tx_in_ready, .tx_in_data, .rx_word,
        .rx_valid, .pclk, .frame_sync, .pcm_din, .pcm_dout, .pcm_dout_oe);
    lhp_hwy_master #(.RX_START_COUNT(2)) i_lhp_hwy_master (.pclk, .frame_sync, .pcm_din, .pcm_dout,
        .pcm_dout_oe, .tx_cap);

    always #20 mclk = ~mclk;
    always @(posedge mclk) if (rx_valid) rx_got <= rx_word;

    task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        cmp("reg_rvalid", 16'h0001, {15'h0000, reg_rvalid});
        cmp($sformatf("reg_%h", a), {8'h00, e}, {8'h00, reg_rdata});
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        cmp("ring_open", 16'h0001, {15'h0000, ring_relay_open});
        foreach (rst_rows[i]) rd(rst_rows[i][15:8], rst_rows[i][7:0]);
        foreach (wr_rows[i]) begin
            wr(wr_rows[i][23:16], wr_rows[i][15:8]);
            rd(wr_rows[i][23:16], wr_rows[i][7:0]);
            if (i == 7) cmp("relays", 16'h0000, {tip_relay_open, ring_relay_open});
        end
        cmp("corner", 16'h0001, {15'h0000, rx_corner_sel});
        cmp("loopback", 16'h0001, {15'h0000, analog_loopback_en});
        wr(8'h20, 8'h00);
        tip_ground_current <= 1'b1;
        repeat (4) @(posedge mclk);
        rd(8'h20, 8'h00);
        wr(8'h20, 8'h02);
        repeat (4) @(posedge mclk);
        rd(8'h20, 8'h06);
        wr(8'h20, 8'h00);
        tip_ground_current <= 1'b0;
        repeat (4) @(posedge mclk);
        rd(8'h20, 8'h04);
        @(posedge mclk);
        line_volt_raw <= 8'h03;
        repeat (3) @(posedge mclk);
        cmp("lv_unforced", 16'h0003, {8'h00, line_voltage_status});
        wr(8'h1F, 8'h00);
        repeat (3) @(posedge mclk);
        cmp("lv_forced", 16'h0000, {8'h00, line_voltage_status});
        offhook_request <= 1'b1;
        repeat (3) @(posedge mclk);
        cmp("loop_hold", 16'h0001, {15'h0000, loop_hold});
        cmp("offhook_early", 16'h0000, {15'h0000, offhook_valid});
        offhook_request <= 1'b0;
        n = 0;
        // fast release must land inside half a millisecond
        while (loop_hold !== 1'b0 && n < 12500) begin
            @(negedge mclk);
            n++;
        end
        cmp("onhook_fast", 16'h0000, {15'h0000, loop_hold});
        // slow release must still hold the loop where the fast one has let go
        wr(8'h1F, 8'h08);
        offhook_request <= 1'b1;
        repeat (3) @(posedge mclk);
        offhook_request <= 1'b0;
        repeat (12500) @(posedge mclk);
        cmp("onhook_slow", 16'h0001, {15'h0000, loop_hold});
        wr(8'h21, 8'h00);
        n = 0;
        tx_in_valid <= 1'b1;
        tx_in_data <= 16'hA000;
        repeat (24) begin
            @(posedge mclk);
            if (tx_in_ready === 1'b1) begin
                n++;
                tx_in_data <= tx_in_data + 16'h0100;
            end
        end
        tx_in_valid <= 1'b0;
        cmp("fifo_fill", 16'h0010, n[15:0]);
        wr(8'h21, 8'h30);
        n = 0;
        while (tx_cap !== 8'hAF && n < 20000) begin
            @(negedge mclk);
            n++;
        end
        cmp("tx_last_byte", 16'h00AF, {8'h00, tx_cap});
        cmp("rx_word", 16'h00C3, rx_got);
        // let the current word finish before the release edge changes
        repeat (16) @(posedge mclk);
        wr(8'h21, 8'h31);
        n = 0;
        while (tx_cap !== 8'h00 && n < 2000) begin
            @(negedge mclk);
            n++;
        end
        cmp("tx_empty_fifo", 16'h0000, {8'h00, tx_cap});
        wr(8'h21, 8'h00);
        // the enable takes one more cycle to stop the shifters
        repeat (2) @(posedge mclk);
        n = 0;
        repeat (1000) @(negedge mclk) if (rx_valid !== 1'b0 || pcm_dout_oe !== 1'b0) n++;
        cmp("disabled_quiet", 16'h0000, n[15:0]);
        complete_run();
    end
endmodule // lhp_regs_test

`default_nettype wire
